//--- core/lpt_map.svh
// register map, field positions and reset values of the low-power periodic timer
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define LPT_IDX_CFG 20'h800B0
`define LPT_IDX_GATE 20'h800B1
`define LPT_IDX_RUN 20'h800B2
`define LPT_IDX_PERIOD 20'h800B4
`define LPT_IDX_PROTECT 20'h800C0
`define LPT_IDX_COUNT 20'h800C1
`define LPT_IDX_LSB 2
`define LPT_IDX_MSB 21
`define LPT_ADDR_HI_LSB 22
`define LPT_ADDR_HI_MSB 31

// ****************************************
// field positions
// ****************************************
`define LPT_PSSEL_LSB 0
`define LPT_PSSEL_MSB 2
`define LPT_CKSEL_BIT 4
`define LPT_CMPEN_BIT 6
`define LPT_GATE_STOP_BIT 0
`define LPT_RUN_BIT 0
`define LPT_CLEAR_BIT 1
`define LPT_WPR_BIT 0
`define LPT_LANE0 0
`define LPT_LANE1 1
`define LPT_BYTE0_LSB 0
`define LPT_BYTE0_MSB 7
`define LPT_BYTE1_LSB 8
`define LPT_BYTE1_MSB 15

// ****************************************
// prescale codes and masks
// ****************************************
`define LPT_PS_DIV2 3'h1
`define LPT_PS_DIV32 3'h5
`define LPT_PS_MASK_ALL 5'h1F
`define LPT_PS_MASK_DIV2 5'h01

// ****************************************
// reset values
// ****************************************
`define LPT_RST_GATE 1'b1
`define LPT_RST_PSSEL 3'h1
`define LPT_RST_PERIOD 16'hFFFF
`define LPT_RST_WPR 1'b0

`endif

//--- core/lpt_pkg.sv
// shared types of the low-power periodic timer
package lpt_pkg;

	typedef enum logic [1:0] {
		LPT_RESP_OKAY = 2'h0,
		LPT_RESP_SLVERR = 2'h2
	} lpt_resp_e;

	typedef enum logic {
		LPT_CLR_IDLE,
		LPT_CLR_BUSY
	} lpt_clr_e;

endpackage

//--- core/lpt_src_sync.sv
// two-flop synchronisers and rising-edge pulses for the oscillator pins
`timescale 1ns/1ps
module lpt_src_sync #(
	parameter int N = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [N-1:0] oscIn,
	output logic [N-1:0] oscRise
);

	logic [N-1:0] meta_reg;
	logic [N-1:0] sync_reg;
	logic [N-1:0] last_reg;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
					last_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= oscIn[i];
					sync_reg[i] <= meta_reg[i];
					last_reg[i] <= sync_reg[i];
				end
			end
			assign oscRise[i] = sync_reg[i] & ~last_reg[i];
		end
	endgenerate

endmodule

//--- core/lpt_prescaler.sv
// divide-by-2..32 prescaler on source clock ticks
`timescale 1ns/1ps
`include "lpt_map.svh"
module lpt_prescaler #(
	parameter int W = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tickIn,
	input wire logic clear,
	input wire logic [2:0] code,
	output logic preTick
);

	logic [W-1:0] preCnt_reg;
	logic [W-1:0] preCnt_next;
	logic [W-1:0] mask;
	logic legal;

	// prohibited codes fall back to divide by two
	assign legal = (code >= `LPT_PS_DIV2) && (code <= `LPT_PS_DIV32);
	assign mask = legal ? (`LPT_PS_MASK_ALL >> (`LPT_PS_DIV32 - code)) : `LPT_PS_MASK_DIV2;
	assign preTick = tickIn && !clear && ((preCnt_reg & mask) == mask);
	assign preCnt_next = preTick ? '0 : preCnt_reg + W'(1);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			preCnt_reg <= '0;
		end else if (clear) begin
			preCnt_reg <= '0;
		end else if (tickIn) begin
			preCnt_reg <= preCnt_next;
		end
	end

	a_tick_restarts: assert property (@(posedge ref_clk) disable iff (rst)
		preTick |=> preCnt_reg == '0)
		else $error("prescaler did not restart after tick");

	a_tick_steps: assert property (@(posedge ref_clk) disable iff (rst)
		tickIn && !clear && !preTick |=> preCnt_reg == $past(preCnt_reg) + W'(1))
		else $error("prescaler did not step on source tick");

endmodule

//--- core/lpt_timer_top.sv
// low-power periodic timer with AXI4-Lite register access
// ****************************************
// Overview of operation
// - Gate bit 0 open lets source clock reach prescaler and counter; 1 blocks it.
// - Run bit 1 with gate open runs prescaler and counter; 0 halts both.
// - Writing 1 to clear bit with gate open resets prescaler and counter on a source edge.
// - Clear bit reads 1 while clearing, drops to 0 by itself when done.
// - 16-bit period value; cycle is source period times ratio times value plus one.
// - Counter equal to period wraps to zero on next count and keeps counting.
// - Unused gate and run bits read zero; software writes zero there.
// - Prescale codes 1 to 5 divide by 2, 4, 8, 16, 32.
// - Source select 0 picks sub-clock oscillator, 1 picks watchdog oscillator.
// - Start by opening the gate, then setting run; counter counts divided ticks.
// ****************************************
`timescale 1ns/1ps
`include "lpt_map.svh"
module lpt_timer_top #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic subOscIn,
	input wire logic wdtOscIn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************
	// register state
	// ****************************************
	logic [2:0] prescaleSelect_reg;
	logic sourceClockSelect_reg, compareEnable_reg, clockGateStop_reg, counterRun_reg, writeProtectRelease_reg;
	logic [CNT_W-1:0] periodValue_reg, count_reg, count_next;
	lpt_pkg::lpt_clr_e clrState_reg, clrState_next;

	// ****************************************
	// bus slave state
	// ****************************************
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next, awready_reg, wready_reg, bvalid_reg, bvalid_next;
	logic arready_reg, rvalid_reg, rvalid_next;
	logic [31:0] awAddr_reg, wData_reg, rdata_reg;
	logic [3:0] wStrb_reg;
	logic [1:0] bresp_reg, rresp_reg;

	// ****************************************
	// write channel decode
	// ****************************************
	logic awTake, wTake, doWrite, wUpperOk, wMapped, wAllowed, lane0, lane1;
	logic wHitCfg, wHitGate, wHitRun, wHitPeriod, wHitProtect, wHitCount;
	logic cfgWrite, gateWrite, runWrite, periodWrite, protectWrite, clearRequest;
	logic [19:0] wIdx;

	assign awTake = s_axi_awvalid && awready_reg;
	assign wTake = s_axi_wvalid && wready_reg;
	assign doWrite = awHeld_reg && wHeld_reg;
	assign wIdx = awAddr_reg[`LPT_IDX_MSB:`LPT_IDX_LSB];
	assign wUpperOk = (awAddr_reg[`LPT_ADDR_HI_MSB:`LPT_ADDR_HI_LSB] == '0);
	assign wHitCfg = wUpperOk && (wIdx == `LPT_IDX_CFG);
	assign wHitGate = wUpperOk && (wIdx == `LPT_IDX_GATE);
	assign wHitRun = wUpperOk && (wIdx == `LPT_IDX_RUN);
	assign wHitPeriod = wUpperOk && (wIdx == `LPT_IDX_PERIOD);
	assign wHitProtect = wUpperOk && (wIdx == `LPT_IDX_PROTECT);
	assign wHitCount = wUpperOk && (wIdx == `LPT_IDX_COUNT);
	assign wMapped = wHitCfg || wHitGate || wHitRun || wHitPeriod || wHitProtect || wHitCount;
	// timer registers ignore writes until the protect release bit is set
	assign wAllowed = doWrite && writeProtectRelease_reg;
	assign lane0 = wStrb_reg[`LPT_LANE0];
	assign lane1 = wStrb_reg[`LPT_LANE1];
	assign cfgWrite = wAllowed && wHitCfg && lane0;
	assign gateWrite = wAllowed && wHitGate && lane0;
	assign runWrite = wAllowed && wHitRun && lane0;
	assign periodWrite = wAllowed && wHitPeriod;
	assign protectWrite = doWrite && wHitProtect && lane0;
	// a clear is only accepted while the source clock is supplied
	assign clearRequest = runWrite && wData_reg[`LPT_CLEAR_BIT] && !clockGateStop_reg;

	assign awHeld_next = (awHeld_reg || awTake) && !doWrite;
	assign wHeld_next = (wHeld_reg || wTake) && !doWrite;
	assign bvalid_next = doWrite || (bvalid_reg && !s_axi_bready);

	// ****************************************
	// read channel decode
	// ****************************************
	logic arTake, rUpperOk, rMapped;
	logic rHitCfg, rHitGate, rHitRun, rHitPeriod, rHitProtect, rHitCount;
	logic [19:0] rIdx;
	logic [7:0] cfgView, gateView, runView;
	logic [31:0] rdMux;

	assign arTake = s_axi_arvalid && arready_reg;
	assign rIdx = s_axi_araddr[`LPT_IDX_MSB:`LPT_IDX_LSB];
	assign rUpperOk = (s_axi_araddr[`LPT_ADDR_HI_MSB:`LPT_ADDR_HI_LSB] == '0);
	assign rHitCfg = rUpperOk && (rIdx == `LPT_IDX_CFG);
	assign rHitGate = rUpperOk && (rIdx == `LPT_IDX_GATE);
	assign rHitRun = rUpperOk && (rIdx == `LPT_IDX_RUN);
	assign rHitPeriod = rUpperOk && (rIdx == `LPT_IDX_PERIOD);
	assign rHitProtect = rUpperOk && (rIdx == `LPT_IDX_PROTECT);
	assign rHitCount = rUpperOk && (rIdx == `LPT_IDX_COUNT);
	assign rMapped = rHitCfg || rHitGate || rHitRun || rHitPeriod || rHitProtect || rHitCount;
	assign cfgView = {1'b0, compareEnable_reg, 1'b0, sourceClockSelect_reg, 1'b0, prescaleSelect_reg};
	assign gateView = {7'h00, clockGateStop_reg};
	// clear bit shows the clear still pending on the source clock
	assign runView = {6'h00, clrState_reg == lpt_pkg::LPT_CLR_BUSY, counterRun_reg};
	assign rdMux = rHitCfg ? {24'h000000, cfgView} :
		rHitGate ? {24'h000000, gateView} :
		rHitRun ? {24'h000000, runView} :
		rHitPeriod ? {16'h0000, periodValue_reg} :
		rHitProtect ? {31'h00000000, writeProtectRelease_reg} :
		rHitCount ? {16'h0000, count_reg} : 32'h00000000;
	assign rvalid_next = arTake || (rvalid_reg && !s_axi_rready);

	// ****************************************
	// source clock select, gate and prescaler
	// ****************************************
	logic [1:0] oscRise;
	logic srcTick, gatedTick, runTick, clearNow, preTick;

	lpt_src_sync #(.N(2)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.oscIn({wdtOscIn, subOscIn}),
		.oscRise(oscRise)
	);

	assign srcTick = sourceClockSelect_reg ? oscRise[1] : oscRise[0];
	assign gatedTick = srcTick && !clockGateStop_reg;
	assign runTick = gatedTick && counterRun_reg;
	assign clearNow = (clrState_reg == lpt_pkg::LPT_CLR_BUSY) && gatedTick;

	lpt_prescaler #(.W(5)) u_pre (
		.ref_clk(ref_clk),
		.rst(rst),
		.tickIn(runTick),
		.clear(clearNow),
		.code(prescaleSelect_reg),
		.preTick(preTick)
	);

	// ****************************************
	// counter and clear handshake
	// ****************************************
	always_comb begin
		count_next = count_reg;
		if (clearNow) begin
			count_next = '0;
		end else if (preTick) begin
			count_next = (count_reg == periodValue_reg) ? '0 : count_reg + CNT_W'(1);
		end
	end

	always_comb begin
		clrState_next = clrState_reg;
		case (clrState_reg)
			lpt_pkg::LPT_CLR_IDLE: begin
				if (clearRequest) begin
					clrState_next = lpt_pkg::LPT_CLR_BUSY;
				end
			end
			lpt_pkg::LPT_CLR_BUSY: begin
				// a new request in the completing cycle keeps the flag set
				if (clearNow && !clearRequest) begin
					clrState_next = lpt_pkg::LPT_CLR_IDLE;
				end
			end
			default: begin
				clrState_next = lpt_pkg::LPT_CLR_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			clrState_reg <= lpt_pkg::LPT_CLR_IDLE;
		end else begin
			count_reg <= count_next;
			clrState_reg <= clrState_next;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prescaleSelect_reg <= `LPT_RST_PSSEL;
			sourceClockSelect_reg <= 1'b0;
			compareEnable_reg <= 1'b0;
			clockGateStop_reg <= `LPT_RST_GATE;
			counterRun_reg <= 1'b0;
			periodValue_reg <= `LPT_RST_PERIOD;
			writeProtectRelease_reg <= `LPT_RST_WPR;
		end else begin
			if (cfgWrite) begin
				prescaleSelect_reg <= wData_reg[`LPT_PSSEL_MSB:`LPT_PSSEL_LSB];
				sourceClockSelect_reg <= wData_reg[`LPT_CKSEL_BIT];
				compareEnable_reg <= wData_reg[`LPT_CMPEN_BIT];
			end
			if (gateWrite) begin
				clockGateStop_reg <= wData_reg[`LPT_GATE_STOP_BIT];
			end
			if (runWrite) begin
				counterRun_reg <= wData_reg[`LPT_RUN_BIT];
			end
			if (periodWrite && lane0) begin
				periodValue_reg[`LPT_BYTE0_MSB:`LPT_BYTE0_LSB] <= wData_reg[`LPT_BYTE0_MSB:`LPT_BYTE0_LSB];
			end
			if (periodWrite && lane1) begin
				periodValue_reg[`LPT_BYTE1_MSB:`LPT_BYTE1_LSB] <= wData_reg[`LPT_BYTE1_MSB:`LPT_BYTE1_LSB];
			end
			if (protectWrite) begin
				writeProtectRelease_reg <= wData_reg[`LPT_WPR_BIT];
			end
		end
	end

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			wStrb_reg <= '0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= lpt_pkg::LPT_RESP_OKAY;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			awready_reg <= !awHeld_next && !bvalid_next;
			wready_reg <= !wHeld_next && !bvalid_next;
			bvalid_reg <= bvalid_next;
			if (awTake) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				bresp_reg <= wMapped ? lpt_pkg::LPT_RESP_OKAY : lpt_pkg::LPT_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= lpt_pkg::LPT_RESP_OKAY;
		end else begin
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
			if (arTake) begin
				rdata_reg <= rdMux;
				rresp_reg <= rMapped ? lpt_pkg::LPT_RESP_OKAY : lpt_pkg::LPT_RESP_SLVERR;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ****************************************
	// assertions
	// ****************************************
	sequence clr_requested;
		clearRequest;
	endsequence
	sequence clr_finishing;
		clrState_reg == lpt_pkg::LPT_CLR_BUSY && gatedTick && !clearRequest;
	endsequence

	a_gate_blocks_count: assert property (@(posedge ref_clk) disable iff (rst)
		clockGateStop_reg |=> count_reg == $past(count_reg))
		else $error("counter moved while source clock gated");
	a_halt_holds_count: assert property (@(posedge ref_clk) disable iff (rst)
		!counterRun_reg && clrState_reg == lpt_pkg::LPT_CLR_IDLE |=> $stable(count_reg))
		else $error("counter moved while halted");
	a_clear_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
		clr_requested |=> clrState_reg == lpt_pkg::LPT_CLR_BUSY)
		else $error("clear flag not set after clear request");
	a_clear_completes: assert property (@(posedge ref_clk) disable iff (rst)
		clr_finishing |=> count_reg == '0 && clrState_reg == lpt_pkg::LPT_CLR_IDLE)
		else $error("clear did not zero counter and drop flag");
	a_wrap_to_zero: assert property (@(posedge ref_clk) disable iff (rst)
		preTick && !clearNow && count_reg == periodValue_reg |=> count_reg == '0)
		else $error("counter did not wrap at period");
	a_count_steps: assert property (@(posedge ref_clk) disable iff (rst)
		preTick && !clearNow && count_reg != periodValue_reg |=> count_reg == $past(count_reg) + CNT_W'(1))
		else $error("counter did not step on prescaler tick");
	a_period_stable: assert property (@(posedge ref_clk) disable iff (rst)
		!periodWrite |=> $stable(periodValue_reg))
		else $error("period changed without a write");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
		arTake && (rHitGate || rHitRun) |=> s_axi_rvalid && s_axi_rdata[31:2] == '0 && !(s_axi_rdata[1] && $past(rHitGate)))
		else $error("reserved control bits read nonzero");

endmodule

//--- dv/tb_low_power_periodic_timer_ctrl.sv
// self-checking bench for the low-power periodic timer
`timescale 1ns/1ps
`include "lpt_map.svh"
module tb_low_power_periodic_timer_ctrl;
	logic refClk;
	logic rst;
	logic subOsc;
	logic wdtOsc;
	logic [31:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [31:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	int fails = 0;
	int testsRun = 0;
	logic [31:0] rdData;
	logic [1:0] rdResp;

	lpt_timer_top dut (.ref_clk(refClk), .rst(rst), .subOscIn(subOsc), .wdtOscIn(wdtOsc),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	always #20 refClk = ~refClk;

	// ****************************************
	// bus and pin tasks
	// ****************************************
	function automatic logic [31:0] ad(input logic [19:0] idx);
		return {10'h000, idx, 2'h0};
	endfunction

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic axiWrite(input logic [31:0] addr, input logic [31:0] data, output logic [1:0] resp);
		logic awDone;
		logic wDone;
		logic bDone;
		awDone = 1'b0;
		wDone = 1'b0;
		bDone = 1'b0;
		@(posedge refClk);
		s_axi_awaddr <= addr;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= data;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bDone) begin
			@(posedge refClk);
			if (!awDone && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				awDone = 1'b1;
			end
			if (!wDone && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				wDone = 1'b1;
			end
			if (s_axi_bvalid === 1'b1) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				bDone = 1'b1;
			end
		end
	endtask

	task automatic axiRead(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] resp);
		logic arDone;
		logic rDone;
		arDone = 1'b0;
		rDone = 1'b0;
		@(posedge refClk);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rDone) begin
			@(posedge refClk);
			if (!arDone && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
				arDone = 1'b1;
			end
			if (s_axi_rvalid === 1'b1) begin
				data = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				rDone = 1'b1;
			end
		end
	endtask

	task automatic wr(input logic [19:0] idx, input logic [31:0] data);
		logic [1:0] resp;
		axiWrite(ad(idx), data, resp);
		check({30'h0, resp}, 32'h0, "write response");
	endtask

	task automatic rd(input logic [19:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] data;
		logic [1:0] resp;
		axiRead(ad(idx), data, resp);
		check({30'h0, resp}, 32'h0, "read response");
		check(data, exp, what);
	endtask

	// one full source period: one bus clock of lead-in, then high and low for four bus clocks each
	task automatic srcTick(input logic useWdt, input int n);
		repeat (n) begin
			@(posedge refClk);
			if (useWdt) begin
				wdtOsc <= 1'b1;
			end else begin
				subOsc <= 1'b1;
			end
			repeat (4) @(posedge refClk);
			subOsc <= 1'b0;
			wdtOsc <= 1'b0;
			repeat (4) @(posedge refClk);
		end
	endtask

	task automatic clearTimer(input logic useWdt);
		int i;
		logic [31:0] data;
		logic [1:0] resp;
		wr(`LPT_IDX_RUN, 32'h2);
		rd(`LPT_IDX_RUN, 32'h2, "clear busy");
		srcTick(useWdt, 1);
		i = 0;
		data = 32'h2;
		while (data[1] !== 1'b0 && i < 20) begin
			axiRead(ad(`LPT_IDX_RUN), data, resp);
			i++;
		end
		check(data, 32'h0, "clear done");
		rd(`LPT_IDX_COUNT, 32'h0, "count after clear");
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		refClk = 1'b0;
		rst = 1'b1;
		subOsc = 1'b0;
		wdtOsc = 1'b0;
		s_axi_awaddr = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 32'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (4) @(posedge refClk);
		rst <= 1'b0;
		rd(`LPT_IDX_CFG, 32'h1, "cfg reset");
		rd(`LPT_IDX_GATE, 32'h1, "gate reset");
		rd(`LPT_IDX_RUN, 32'h0, "run reset");
		rd(`LPT_IDX_PERIOD, 32'hFFFF, "period reset");
		rd(`LPT_IDX_COUNT, 32'h0, "count reset");
		rd(`LPT_IDX_PROTECT, 32'h0, "protect reset");
		wr(`LPT_IDX_GATE, 32'h0);
		rd(`LPT_IDX_GATE, 32'h1, "write while protected");
		axiRead(ad(20'h800B3), rdData, rdResp);
		check({30'h0, rdResp}, {30'h0, 2'(lpt_pkg::LPT_RESP_SLVERR)}, "unmapped read response");
		check(rdData, 32'h0, "unmapped read data");
		axiWrite(ad(20'h800B3), 32'hFFFFFFFF, rdResp);
		check({30'h0, rdResp}, {30'h0, 2'(lpt_pkg::LPT_RESP_SLVERR)}, "unmapped write response");
		wr(`LPT_IDX_PROTECT, 32'h1);
		wr(`LPT_IDX_GATE, 32'hFF);
		rd(`LPT_IDX_GATE, 32'h1, "gate unused bits");
		wr(`LPT_IDX_GATE, 32'h0);
		wr(`LPT_IDX_PERIOD, 32'h3);
		rd(`LPT_IDX_PERIOD, 32'h3, "period readback");
		wr(`LPT_IDX_RUN, 32'hFD);
		rd(`LPT_IDX_RUN, 32'h1, "run unused bits");
		srcTick(1'b0, 10);
		rd(`LPT_IDX_COUNT, 32'h1, "wrap after period");
		wr(`LPT_IDX_GATE, 32'h1);
		srcTick(1'b0, 4);
		rd(`LPT_IDX_COUNT, 32'h1, "gate blocks");
		wr(`LPT_IDX_GATE, 32'h0);
		wr(`LPT_IDX_RUN, 32'h0);
		srcTick(1'b0, 4);
		rd(`LPT_IDX_COUNT, 32'h1, "run off halts");
		clearTimer(1'b0);
		for (int code = 1; code <= 5; code++) begin
			wr(`LPT_IDX_GATE, 32'h1);
			wr(`LPT_IDX_CFG, 32'(code));
			wr(`LPT_IDX_GATE, 32'h0);
			clearTimer(1'b0);
			wr(`LPT_IDX_RUN, 32'h1);
			srcTick(1'b0, (3 << code) - 1);
			rd(`LPT_IDX_COUNT, 32'h2, "one tick short");
			srcTick(1'b0, 1);
			rd(`LPT_IDX_COUNT, 32'h3, "divided count");
			wr(`LPT_IDX_RUN, 32'h0);
		end
		wr(`LPT_IDX_GATE, 32'h1);
		wr(`LPT_IDX_CFG, 32'h51);
		rd(`LPT_IDX_CFG, 32'h51, "cfg readback");
		wr(`LPT_IDX_GATE, 32'h0);
		clearTimer(1'b1);
		wr(`LPT_IDX_RUN, 32'h1);
		srcTick(1'b0, 4);
		rd(`LPT_IDX_COUNT, 32'h0, "unselected source");
		srcTick(1'b1, 4);
		rd(`LPT_IDX_COUNT, 32'h2, "selected source");
		wr(`LPT_IDX_RUN, 32'h0);
		stop_test();
	end

	// the sequence needs roughly 2300 bus clocks
	initial begin
		repeat (20000) @(posedge refClk);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		stop_test();
	end
endmodule
